// *** rtl/stack_ea_gen.sv ***
// Stack pointer and effective-address generator
`timescale 1ns/1ps
`include "agu_map.svh"
module stack_ea_gen (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire agu_pkg::ea_req_t      ea_req,
  input  wire agu_pkg::stack_req_t   stk_req,
  input  wire logic                  w_wr_en,
  input  wire logic [3:0]            w_wr_sel,
  input  wire logic [15:0]           w_wr_data,
  input  wire logic                  limit_wr_en,
  input  wire logic [15:0]           limit_wr_data,
  input  wire agu_pkg::code_seg_t    code_seg,
  input  wire logic                  boot_secure_en,
  input  wire logic [15:0]           boot_secure_lo,
  input  wire logic [15:0]           boot_secure_hi,
  input  wire logic                  general_secure_en,
  input  wire logic [15:0]           general_secure_lo,
  input  wire logic [15:0]           general_secure_hi,
  output agu_pkg::ea_resp_t          ea_resp,
  output logic [15:0]                stack_pointer_reg,
  output logic [15:0]                stack_limit_reg,
  output logic [15:0]                default_work_reg,
  output logic                       stack_error,
  output logic                       access_denied
);
  import agu_pkg::*;

  typedef struct packed {
    logic [15:0][15:0] work_regs;
    logic [15:0]       limit;
    ea_resp_t          resp;
    logic              stk_err;
    logic              deny;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  logic [15:0] base_val;
  logic [15:0] offs_val;
  logic [15:0] ea_addr;
  logic [15:0] ea_ptr_new;
  logic        ea_uses_sp;
  logic [15:0] sp_addr;
  logic [15:0] sp_new;
  logic [15:0] push_word;
  logic        ovf_ea;
  logic        unf_ea;
  logic        ovf_stk;
  logic        unf_stk;
  logic        gate_deny;
  logic [15:0] chk_addr;

  function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
    add16 = a + b;
  endfunction

  function automatic logic [15:0] lit_ext(input logic [9:0] lit, input logic long_lit);
    lit_ext = long_lit ? {6'h00, lit} : {11'h000, lit[4:0]};
  endfunction

  assign base_val = state_ff.work_regs[ea_req.base_sel];
  assign offs_val = state_ff.work_regs[ea_req.offset_sel];
  assign ea_uses_sp = ea_req.valid & (ea_req.base_sel == `AGU_SP_INDEX) &
                      (ea_req.mode inside {md_reg_indirect, md_post_mod, md_pre_mod,
                                           md_indexed, md_lit_offset});

  always_comb begin
    ea_addr    = 16'h0000;
    ea_ptr_new = base_val;
    case (ea_req.mode)
      md_file_direct: begin
        if (ea_req.is_move) begin
          ea_addr = {3'h0, ea_req.faddr};
        end else begin
          ea_addr = {3'h0, ea_req.faddr[`AGU_FADDR_W-1:0]};
        end
      end
      md_reg_indirect: begin
        ea_addr = base_val;
      end
      md_post_mod: begin
        ea_addr    = base_val;
        ea_ptr_new = add16(base_val, ea_req.modifier);
      end
      md_pre_mod: begin
        ea_ptr_new = add16(base_val, ea_req.modifier);
        ea_addr    = ea_ptr_new;
      end
      md_indexed: begin
        ea_addr = add16(base_val, offs_val);
      end
      md_lit_offset: begin
        ea_addr = add16(base_val, lit_ext(ea_req.literal, ea_req.lit_long));
      end
      default: begin
        ea_addr = 16'h0000;
      end
    endcase
  end

  // Stack transfers: pop predecrements, push writes then increments
  always_comb begin
    sp_addr = state_ff.work_regs[`AGU_SP_INDEX];
    sp_new  = sp_addr;
    if (stk_req.op == st_pop) begin
      sp_addr = state_ff.work_regs[`AGU_SP_INDEX] - `AGU_WORD_STEP;
      sp_new  = sp_addr;
    end else if (stk_req.op == st_push) begin
      sp_new = state_ff.work_regs[`AGU_SP_INDEX] + `AGU_WORD_STEP;
    end
  end

  always_comb begin
    push_word = 16'h0000;
    case (stk_req.fmt)
      pf_call: begin
        push_word = stk_req.high_word ? {9'h000, stk_req.pc[22:16]} : stk_req.pc[15:0];
      end
      pf_exception: begin
        push_word = stk_req.high_word ? {stk_req.status_low_byte, 1'b0, stk_req.pc[22:16]}
                                      : stk_req.pc[15:0];
      end
      default: begin
        push_word = stk_req.pc[15:0];
      end
    endcase
  end

  stack_limit_check u_ea_chk (
    .is_push   ((ea_req.mode == md_post_mod) & ~ea_req.modifier[15]),
    .uses_sp   (ea_uses_sp),
    .ea        (ea_addr),
    .limit     (state_ff.limit),
    .overflow  (ovf_ea),
    .underflow (unf_ea)
  );

  stack_limit_check u_stk_chk (
    .is_push   (stk_req.op == st_push),
    .uses_sp   (stk_req.valid & (stk_req.op != st_none)),
    .ea        (sp_addr),
    .limit     (state_ff.limit),
    .overflow  (ovf_stk),
    .underflow (unf_stk)
  );

  assign chk_addr = (stk_req.valid && stk_req.op != st_none) ? sp_addr : ea_addr;

  secure_ram_gate u_gate (
    .boot_en  (boot_secure_en),
    .boot_lo  (boot_secure_lo),
    .boot_hi  (boot_secure_hi),
    .gen_en   (general_secure_en),
    .gen_lo   (general_secure_lo),
    .gen_hi   (general_secure_hi),
    .code_seg (code_seg),
    .addr     (chk_addr),
    .deny     (gate_deny)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_state.stk_err = 1'b0;
    nxt_state.deny    = 1'b0;
    nxt_state.resp    = '0;
    if (w_wr_en) begin
      nxt_state.work_regs[w_wr_sel] = w_wr_data;
      if (w_wr_sel == `AGU_SP_INDEX) begin
        nxt_state.work_regs[w_wr_sel][0] = 1'b0;
      end
    end
    if (limit_wr_en) begin
      nxt_state.limit = {limit_wr_data[15:1], 1'b0};
    end
    if (stk_req.valid && stk_req.op != st_none) begin
      nxt_state.resp.valid    = 1'b1;
      nxt_state.resp.addr     = sp_addr;
      nxt_state.resp.wr_en    = (stk_req.op == st_push) & ~ovf_stk & ~unf_stk & ~gate_deny;
      nxt_state.resp.wr_data  = push_word;
      nxt_state.resp.fault    = ovf_stk | unf_stk | gate_deny;
      nxt_state.resp.ptr_wr   = 1'b1;
      nxt_state.resp.ptr_sel  = `AGU_SP_INDEX;
      nxt_state.resp.ptr_val  = sp_new;
      nxt_state.work_regs[`AGU_SP_INDEX] = sp_new;
      nxt_state.stk_err = ovf_stk | unf_stk;
      nxt_state.deny    = gate_deny;
    end else if (ea_req.valid) begin
      nxt_state.resp.valid    = 1'b1;
      nxt_state.resp.dest_sel = ea_req.dest_is_work ? `AGU_WORK_INDEX : ea_req.base_sel;
      if (ea_req.is_multiply) begin
        nxt_state.resp.dest_sel = ea_req.offset_sel;
      end
      if (ea_req.mode == md_reg_direct) begin
        nxt_state.resp.is_operand = 1'b1;
        nxt_state.resp.operand    = base_val;
      end else if (ea_req.mode == md_literal) begin
        nxt_state.resp.is_operand = 1'b1;
        nxt_state.resp.operand    = lit_ext(ea_req.literal, ea_req.lit_long);
      end else begin
        nxt_state.resp.addr  = ea_addr;
        nxt_state.resp.fault = ((ovf_ea | unf_ea) & ea_uses_sp) | gate_deny;
        nxt_state.stk_err    = (ovf_ea | unf_ea) & ea_uses_sp;
        nxt_state.deny       = gate_deny;
      end
      if (ea_req.mode == md_post_mod || ea_req.mode == md_pre_mod) begin
        nxt_state.resp.ptr_wr  = 1'b1;
        nxt_state.resp.ptr_sel = ea_req.base_sel;
        nxt_state.resp.ptr_val = ea_ptr_new;
        nxt_state.work_regs[ea_req.base_sel] = ea_ptr_new;
      end
    end
  end

  // Limit keeps no reset value; pointer starts above special function space
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff.work_regs <= '0;
      state_ff.work_regs[`AGU_SP_INDEX] <= `AGU_SP_RESET;
      state_ff.limit   <= nxt_state.limit;
      state_ff.resp    <= '0;
      state_ff.stk_err <= 1'b0;
      state_ff.deny    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign ea_resp           = state_ff.resp;
  assign stack_pointer_reg = state_ff.work_regs[`AGU_SP_INDEX];
  assign stack_limit_reg   = {state_ff.limit[15:1], 1'b0};
  assign default_work_reg  = state_ff.work_regs[`AGU_WORK_INDEX];
  assign stack_error       = state_ff.stk_err;
  assign access_denied     = state_ff.deny;
endmodule

// *** common/agu_map.svh ***
// Constants for stack and effective-address generation
`ifndef AGU_MAP_SVH
`define AGU_MAP_SVH
`define AGU_NEAR_LIMIT      16'h2000
`define AGU_SFR_FLOOR       16'h0800
`define AGU_SP_INDEX        4'hF
`define AGU_WORK_INDEX      4'h0
`define AGU_WORD_STEP       16'h0002
`define AGU_SP_RESET        16'h0800
`define AGU_FADDR_W         13
`define AGU_LIT5_W          5
`define AGU_LIT10_W         10
`define AGU_PC_W            23
`endif

// *** common/agu_pkg.sv ***
// Types for stack and effective-address generation
package agu_pkg;
  typedef enum logic [2:0] {
    md_file_direct,
    md_reg_direct,
    md_reg_indirect,
    md_post_mod,
    md_pre_mod,
    md_indexed,
    md_lit_offset,
    md_literal
  } addr_mode_t;

  typedef enum logic [1:0] {
    st_none,
    st_push,
    st_pop
  } stack_op_t;

  typedef enum logic [1:0] {
    pf_plain,
    pf_call,
    pf_exception
  } push_fmt_t;

  typedef enum logic [1:0] {
    seg_open,
    seg_boot,
    seg_secure
  } code_seg_t;

  typedef struct packed {
    logic                 valid;
    addr_mode_t           mode;
    logic [3:0]           base_sel;
    logic [3:0]           offset_sel;
    logic [12:0]          faddr;
    logic signed [15:0]   modifier;
    logic [9:0]           literal;
    logic                 lit_long;
    logic                 is_move;
    logic                 dest_is_work;
    logic                 is_multiply;
  } ea_req_t;

  typedef struct packed {
    logic                 valid;
    stack_op_t            op;
    push_fmt_t            fmt;
    logic [22:0]          pc;
    logic [7:0]           status_low_byte;
    logic                 high_word;
  } stack_req_t;

  typedef struct packed {
    logic                 valid;
    logic [15:0]          addr;
    logic                 is_operand;
    logic [15:0]          operand;
    logic                 wr_en;
    logic [15:0]          wr_data;
    logic                 ptr_wr;
    logic [3:0]           ptr_sel;
    logic [15:0]          ptr_val;
    logic [3:0]           dest_sel;
    logic                 fault;
  } ea_resp_t;
endpackage

// *** rtl/stack_limit_check.sv ***
// Stack limit and underflow comparator
`timescale 1ns/1ps
`include "agu_map.svh"
module stack_limit_check (
  input  wire logic        is_push,
  input  wire logic        uses_sp,
  input  wire logic [15:0] ea,
  input  wire logic [15:0] limit,
  output logic             overflow,
  output logic             underflow
);
  import agu_pkg::*;
  // Push at sp == limit allowed; only addresses past it trap
  assign overflow  = uses_sp & is_push & (ea > limit);
  assign underflow = uses_sp & (ea < `AGU_SFR_FLOOR);
endmodule

// *** rtl/secure_ram_gate.sv ***
// Secure RAM segment access gate
`timescale 1ns/1ps
module secure_ram_gate (
  input  wire logic               boot_en,
  input  wire logic [15:0]        boot_lo,
  input  wire logic [15:0]        boot_hi,
  input  wire logic               gen_en,
  input  wire logic [15:0]        gen_lo,
  input  wire logic [15:0]        gen_hi,
  input  wire agu_pkg::code_seg_t code_seg,
  input  wire logic [15:0]        addr,
  output logic                    deny
);
  import agu_pkg::*;
  logic in_boot;
  logic in_gen;
  assign in_boot = boot_en & (addr >= boot_lo) & (addr <= boot_hi);
  assign in_gen  = gen_en & (addr >= gen_lo) & (addr <= gen_hi);
  assign deny    = (in_boot & (code_seg != seg_boot)) | (in_gen & (code_seg != seg_secure));
endmodule

// *** verification/stack_ea_monitor.sv ***
// Checker for stack and address generation
`timescale 1ns/1ps
module stack_ea_monitor (
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire agu_pkg::ea_req_t    ea_req,
  input wire agu_pkg::stack_req_t stk_req,
  input wire logic                limit_wr_en,
  input wire logic [15:0]         limit_wr_data,
  input wire agu_pkg::ea_resp_t   ea_resp,
  input wire logic [15:0]         stack_pointer_reg,
  input wire logic [15:0]         stack_limit_reg,
  input wire logic                stack_error
);
  import agu_pkg::*;
  wire logic        psh = stk_req.valid && stk_req.op == st_push;
  wire logic        pop = stk_req.valid && stk_req.op == st_pop;
  wire logic        stk = psh || pop;
  wire logic        hiw = psh && stk_req.high_word;
  wire logic [7:0]  sbyte = stk_req.status_low_byte;
  wire logic [6:0]  pch = stk_req.pc[22:16];
  wire logic [15:0] sp  = stack_pointer_reg;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_push_addr: assert property (psh |=> ea_resp.addr == $past(sp) && sp == $past(sp) + 16'h0002)
    else $error("push address or step wrong");
  chk_pop_addr: assert property (pop |=> ea_resp.addr == $past(sp) - 16'h0002 && sp == ea_resp.addr)
    else $error("pop address or step wrong");
  chk_call_msb: assert property (hiw && stk_req.fmt == pf_call |=> ea_resp.wr_data[15:7] == 9'h000)
    else $error("call push top bits not zero");
  chk_exc_word: assert property (hiw && stk_req.fmt == pf_exception |=>
    ea_resp.wr_data == {$past(sbyte), 1'b0, $past(pch)})
    else $error("exception push word wrong");
  chk_over_trap: assert property (psh && sp > stack_limit_reg && sp >= 16'h0800 |=>
    stack_error && ea_resp.fault && !ea_resp.wr_en)
    else $error("limit overflow not trapped");
  chk_under_trap: assert property (pop && sp < 16'h0802 |=> stack_error)
    else $error("underflow not trapped");
  chk_err_cause: assert property (stack_error |-> $past(stk || ea_req.valid))
    else $error("stack error without stack or address request");
  chk_limit_even: assert property (limit_wr_en |=> stack_limit_reg == ($past(limit_wr_data) & 16'hFFFE))
    else $error("limit write wrong");
  cover property (psh && sp == stack_limit_reg);
  cover property (ea_req.valid && ea_req.base_sel == 4'hF && ea_req.mode == md_post_mod);
  cover property (stack_error);
  cover property (pop && sp < 16'h0802);
endmodule

bind stack_ea_gen stack_ea_monitor u_stack_ea_monitor (.ref_clk(ref_clk), .rst(rst), .ea_req(ea_req), .stk_req(stk_req),
  .limit_wr_en(limit_wr_en), .limit_wr_data(limit_wr_data), .ea_resp(ea_resp),
  .stack_pointer_reg(stack_pointer_reg), .stack_limit_reg(stack_limit_reg), .stack_error(stack_error));

// *** verification/data_mem_model.sv ***
// Data memory model written through the address generator
`timescale 1ns/1ps
module data_mem_model (
  input wire logic              ref_clk,
  input wire agu_pkg::ea_resp_t ea_resp
);
  logic [15:0] mem [logic [15:0]];
  always @(posedge ref_clk) begin
    if (ea_resp.valid && ea_resp.wr_en) begin
      mem[ea_resp.addr] = ea_resp.wr_data;
    end
  end
  // Unwritten words read as all ones
  function automatic logic [15:0] peek(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
endmodule

// *** verification/stack_ea_gen_bench.sv ***
// Self-checking bench for the stack and address generator
`timescale 1ns/1ps
module stack_ea_gen_bench;
  import agu_pkg::*;
  logic        ref_clk, rst, w_wr_en, limit_wr_en, bs_en, gs_en, stack_error, access_denied;
  logic [3:0]  w_wr_sel;
  logic [15:0] w_wr_data, limit_wr_data, sp, lim, work0, bs_lo, bs_hi, gs_lo, gs_hi;
  ea_req_t     ea_req;
  stack_req_t  stk_req;
  code_seg_t   code_seg;
  ea_resp_t    ea_resp;
  int          n_mismatch = 0;
  int          num_checks = 0;
  stack_ea_gen u_stack_ea_gen (.ref_clk(ref_clk), .rst(rst), .ea_req(ea_req), .stk_req(stk_req),
    .w_wr_en(w_wr_en), .w_wr_sel(w_wr_sel), .w_wr_data(w_wr_data), .limit_wr_en(limit_wr_en),
    .limit_wr_data(limit_wr_data), .code_seg(code_seg), .boot_secure_en(bs_en), .boot_secure_lo(bs_lo),
    .boot_secure_hi(bs_hi), .general_secure_en(gs_en), .general_secure_lo(gs_lo),
    .general_secure_hi(gs_hi), .ea_resp(ea_resp), .stack_pointer_reg(sp), .stack_limit_reg(lim),
    .default_work_reg(work0), .stack_error(stack_error), .access_denied(access_denied));
  data_mem_model u_data_mem_model (.ref_clk(ref_clk), .ea_resp(ea_resp));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Drops every request; results of the last one are readable on return
  task automatic idle;
    @(posedge ref_clk);
    ea_req.valid <= 1'b0;
    stk_req.valid <= 1'b0;
    w_wr_en <= 1'b0;
    limit_wr_en <= 1'b0;
    #1;
  endtask
  task automatic stk(input stack_op_t op, input push_fmt_t f, input logic [22:0] pc, input logic hw);
    @(posedge ref_clk);
    stk_req <= '{1'b1, op, f, pc, 8'hA5, hw};
  endtask
  task automatic wr(input logic [3:0] sel, input logic [15:0] d);
    @(posedge ref_clk);
    w_wr_en <= 1'b1;
    w_wr_sel <= sel;
    w_wr_data <= d;
    idle();
  endtask
  task automatic ea(input addr_mode_t m, input logic [12:0] fa, input logic [15:0] md, input logic [9:0] lit,
                    input logic lng, input logic [15:0] exp);
    @(posedge ref_clk);
    ea_req <= '{1'b1, m, 4'h2, 4'h3, fa, md, lit, lng, 1'b0, 1'b1, 1'b0};
    idle();
    check(ea_resp.is_operand ? ea_resp.operand : ea_resp.addr, exp);
    check({12'h000, ea_resp.dest_sel}, 16'h0000);
  endtask
  task automatic t_push;
    @(posedge ref_clk);
    limit_wr_en <= 1'b1;
    limit_wr_data <= 16'h0FFF;
    idle();
    idle();
    check(lim, 16'h0FFE);
    stk(st_push, pf_call, 23'h5A1234, 1'b0);
    stk(st_push, pf_call, 23'h5A1234, 1'b1);
    stk(st_push, pf_exception, 23'h3C5678, 1'b0);
    stk(st_push, pf_exception, 23'h3C5678, 1'b1);
    idle();
    idle();
    check(sp, 16'h0808);
    check(u_data_mem_model.peek(16'h0800), 16'h1234);
    check(u_data_mem_model.peek(16'h0802), 16'h005A);
    check(u_data_mem_model.peek(16'h0804), 16'h5678);
    check(u_data_mem_model.peek(16'h0806), 16'hA53C);
    stk(st_pop, pf_plain, 23'h0, 1'b0);
    idle();
    check(ea_resp.addr, 16'h0806);
  endtask
  task automatic t_limit;
    wr(4'hF, 16'h0FFC);
    check(sp, 16'h0FFC);
    for (int i = 0; i < 3; i++) begin
      stk(st_push, pf_plain, 23'h0, 1'b0);
      idle();
      check(stack_error, i == 2);
    end
    check(ea_resp.wr_en, 1'b0);
    check(sp, 16'h1002);
    idle();
    check(stack_error, 1'b0);
  endtask
  task automatic t_under;
    wr(4'hF, 16'h0802);
    for (int i = 0; i < 2; i++) begin
      stk(st_pop, pf_plain, 23'h0, 1'b0);
      idle();
      check(stack_error, i == 1);
    end
  endtask
  // Post-increment through the stack pointer past the limit
  task automatic t_ea_sp;
    wr(4'hF, 16'h1000);
    @(posedge ref_clk);
    ea_req <= '{1'b1, md_post_mod, 4'hF, 4'h3, 13'h0000, 16'h0002, 10'h000, 1'b0, 1'b0, 1'b1, 1'b0};
    idle();
    check(stack_error, 1'b1);
    check(ea_resp.fault, 1'b1);
    check(ea_resp.addr, 16'h1000);
    check(sp, 16'h1002);
    idle();
    check(stack_error, 1'b0);
  endtask
  task automatic t_modes;
    wr(4'h0, 16'h0040);
    check(work0, 16'h0040);
    wr(4'h2, 16'h1000);
    wr(4'h3, 16'h0010);
    ea(md_file_direct, 13'h1ABC, 16'h0000, 10'h000, 1'b0, 16'h1ABC);
    ea(md_reg_direct, 13'h0000, 16'h0000, 10'h000, 1'b0, 16'h1000);
    ea(md_reg_indirect, 13'h0000, 16'h0000, 10'h000, 1'b0, 16'h1000);
    ea(md_post_mod, 13'h0000, 16'h0002, 10'h000, 1'b0, 16'h1000);
    check(ea_resp.ptr_val, 16'h1002);
    ea(md_pre_mod, 13'h0000, 16'hFFFE, 10'h000, 1'b0, 16'h1000);
    ea(md_indexed, 13'h0000, 16'h0000, 10'h000, 1'b0, 16'h1010);
    ea(md_lit_offset, 13'h0000, 16'h0000, 10'h020, 1'b1, 16'h1020);
    ea(md_literal, 13'h0000, 16'h0000, 10'h3F5, 1'b0, 16'h0015);
    ea(md_literal, 13'h0000, 16'h0000, 10'h3F5, 1'b1, 16'h03F5);
  endtask
  task automatic sec(input code_seg_t s, input logic [12:0] a, input logic exp);
    @(posedge ref_clk);
    code_seg <= s;
    bs_en <= 1'b1;
    gs_en <= 1'b1;
    ea(md_file_direct, a, 16'h0000, 10'h000, 1'b0, {3'b000, a});
    check(access_denied, exp);
  endtask
  initial begin
    rst = 1'b1;
    bs_lo = 16'h0C00;
    bs_hi = 16'h0CFF;
    gs_lo = 16'h0D00;
    gs_hi = 16'h0DFF;
    ea_req = '0;
    stk_req = '0;
    w_wr_en = 1'b0;
    w_wr_sel = 4'h0;
    w_wr_data = 16'h0000;
    limit_wr_en = 1'b0;
    limit_wr_data = 16'h0000;
    code_seg = seg_open;
    bs_en = 1'b0;
    gs_en = 1'b0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    idle();
    check(sp, 16'h0800);
    t_push();
    t_limit();
    t_under();
    t_ea_sp();
    t_modes();
    sec(seg_open, 13'h0C10, 1'b1);
    sec(seg_boot, 13'h0C10, 1'b0);
    sec(seg_boot, 13'h0D10, 1'b1);
    sec(seg_secure, 13'h0D10, 1'b0);
    report_and_stop();
  end
  initial begin
    #(3000 * 50);
    n_mismatch++;
    report_and_stop();
  end
endmodule
